/* hw/ecrb_params.svh */
`ifndef ECRB_PARAMS_SVH
`define ECRB_PARAMS_SVH

// ****************************************
// register space
// ****************************************
`define ECRB_WORD_COUNT 256
`define ECRB_BYTE_SPAN 10'h300
`define ECRB_BYTES_PER_WORD 10'h003
`define ECRB_ADDR_CONFIG 8'h02
`define ECRB_ADDR_CONTROL 8'h03
`define ECRB_ADDR_INDIRECT_READ_ADDRESS 8'h0B
`define ECRB_ADDR_INDIRECT_READ_VALUE 8'h0C
`define ECRB_ADDR_SCRATCH_BASE 8'hF8
`define ECRB_SCRATCH_COUNT 8

// ****************************************
// reset values and masks
// ****************************************
`define ECRB_CONFIG_RST 24'h000000
`define ECRB_CONTROL_RST 24'h000000
`define ECRB_SCRATCH0_RST 24'h00003E
`define ECRB_SCRATCH1_RST 24'h00029B
`define ECRB_SCRATCH_RST 24'h000000
`define ECRB_CONTROL_WMASK 24'h000074
`define ECRB_IND_ADDR_MASK 24'h0000FF
`define ECRB_POS_MAX 24'h7FFFFF
`define ECRB_NEG_MAX 24'h800000

`endif

/* hw/ecrb_pkg.sv */
package ecrb_pkg;

	// sensor configuration word layout
	typedef struct packed {
		logic rsv_23;
		logic invert_voltage_in3;
		logic invert_voltage_in2;
		logic invert_voltage_in1;
		logic phase_c_sign_out_en;
		logic phase_b_sign_out_en;
		logic phase_a_sign_out_en;
		logic [8:0] rsv_16_8;
		logic [1:0] power_phase_exclude;
		logic delta_voltage_mode;
		logic [1:0] missing_voltage_sensor;
		logic neutral_leg_current;
		logic [1:0] missing_current_sensor;
	} ecrb_cfg_s;

	// operating control word layout
	typedef struct packed {
		logic [16:0] rsv_23_7;
		logic io5_select_en;
		logic line_lock;
		logic temp_gain_comp_en;
		logic rsv_3;
		logic single_target;
		logic [1:0] rsv_1_0;
	} ecrb_ctrl_s;

	typedef struct packed {
		logic wr;
		logic byte_mode;
		logic [9:0] addr;
		logic [23:0] wdata;
	} ecrb_host_req_s;

	typedef enum logic [1:0] {
		ECRB_IDLE = 2'b00,
		ECRB_HOST = 2'b01,
		ECRB_IND_FETCH = 2'b10,
		ECRB_IND_LOAD = 2'b11
	} ecrb_state_e;

endpackage

/* hw/ecrb_ram.sv */
`timescale 1ns/1ns
module ecrb_ram (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic we,
	input wire logic [7:0] addr,
	input wire logic [23:0] wdata,
	output logic [23:0] rdata
);
	logic [23:0] mem [0:255];

	always_ff @(posedge mclk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= 24'h000000;
		end else begin
			rdata <= mem[addr];
		end
	end
endmodule

/* hw/ecrb_top.sv */
`timescale 1ns/1ns
`include "ecrb_params.svh"

module ecrb_top (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic host_req,
	input wire ecrb_pkg::ecrb_host_req_s host_cmd,
	output logic host_ack,
	output logic host_addr_err,
	output logic [23:0] host_rdata,
	input wire logic sample_tick,
	input wire logic flash_save,
	input wire logic flash_restore,
	input wire logic uart_mode_pin,
	input wire logic device_selected,
	input wire logic [23:0] voltage_input_1,
	input wire logic [23:0] voltage_input_2,
	input wire logic [23:0] voltage_input_3,
	output logic [23:0] phase_voltage_a,
	output logic [23:0] phase_voltage_b,
	output logic [23:0] phase_voltage_c,
	output logic [2:0] power_phase_include,
	output logic [2:0] voltage_present,
	output logic [2:0] current_present,
	output logic delta_voltage_mode,
	output logic neutral_leg_current,
	output logic line_lock,
	output logic temp_gain_comp_en,
	output logic single_target_mode,
	output logic multipurpose_pin_5,
	output logic multipurpose_pin_5_oe_n,
	output logic multipurpose_pin_6,
	output logic multipurpose_pin_6_oe_n,
	output logic multipurpose_pin_7,
	output logic multipurpose_pin_7_oe_n,
	output logic multipurpose_pin_8,
	output logic multipurpose_pin_8_oe_n
);
	// ****************************************
	// functions
	// ****************************************
	function automatic logic [23:0] sat_neg(input logic [23:0] v);
		sat_neg = (v == `ECRB_NEG_MAX) ? `ECRB_POS_MAX : (~v + 24'h000001);
	endfunction

	function automatic logic [23:0] sat_sub(input logic [23:0] a, input logic [23:0] b);
		logic [24:0] d;
		d = {a[23], a} - {b[23], b};
		if (d[24] != d[23]) begin
			sat_sub = d[24] ? `ECRB_NEG_MAX : `ECRB_POS_MAX;
		end else begin
			sat_sub = d[23:0];
		end
	endfunction

	// two-bit "which one is missing" code to a presence mask
	function automatic logic [2:0] present_mask(input logic [1:0] code);
		case (code)
			2'b01: present_mask = 3'b110;
			2'b10: present_mask = 3'b101;
			2'b11: present_mask = 3'b011;
			default: present_mask = 3'b111;
		endcase
	endfunction

	// returns {error, word}
	function automatic logic [8:0] to_word(input logic byte_mode, input logic [9:0] a);
		logic [9:0] w;
		w = a / `ECRB_BYTES_PER_WORD;
		if (byte_mode) begin
			to_word = {(a >= `ECRB_BYTE_SPAN) || (a % `ECRB_BYTES_PER_WORD != 10'h000), w[7:0]};
		end else begin
			to_word = {a[9:8] != 2'b00, a[7:0]};
		end
	endfunction

	// ****************************************
	// registers
	// ****************************************
	ecrb_pkg::ecrb_cfg_s cfg;
	ecrb_pkg::ecrb_ctrl_s ctrl;
	logic [23:0] scratch [0:7];
	logic [23:0] nv_cfg;
	ecrb_pkg::ecrb_ctrl_s nv_ctrl;
	logic [23:0] nv_scratch [0:7];
	logic [23:0] ind_addr;
	logic [23:0] ind_data;
	ecrb_pkg::ecrb_state_e state;
	ecrb_pkg::ecrb_state_e next_state;
	logic tick_pending;
	logic init_done;
	logic hit_q;
	logic [23:0] local_q;
	logic wr_q;
	logic err_q;
	logic uart_s1;
	logic uart_s2;
	logic uart_s3;
	logic uart_mode;
	logic [23:0] v1_q;
	logic [23:0] v2_q;
	logic [23:0] v3_q;

	// ****************************************
	// decode
	// ****************************************
	wire [8:0] host_conv = to_word(host_cmd.byte_mode, host_cmd.addr);
	wire host_err = host_conv[8];
	// the ack edge closes an access, it never opens a second one
	wire host_take = (state == ecrb_pkg::ECRB_IDLE) && host_req && !tick_pending && !host_ack;
	wire ind_go = (state == ecrb_pkg::ECRB_IDLE) && tick_pending && (ind_addr[23:8] != 16'h0000);
	wire [7:0] ind_word = ind_addr[7:0];
	wire [7:0] sel_word = (state == ecrb_pkg::ECRB_IDLE) ? (ind_go ? ind_word : host_conv[7:0])
		: ind_word;
	wire hit_cfg = sel_word == `ECRB_ADDR_CONFIG;
	wire hit_ctrl = sel_word == `ECRB_ADDR_CONTROL;
	wire hit_iaddr = sel_word == `ECRB_ADDR_INDIRECT_READ_ADDRESS;
	wire hit_idata = sel_word == `ECRB_ADDR_INDIRECT_READ_VALUE;
	wire hit_scr = sel_word[7:3] == `ECRB_ADDR_SCRATCH_BASE >> 3;
	wire local_hit = hit_cfg || hit_ctrl || hit_iaddr || hit_idata || hit_scr;
	wire [23:0] local_val = hit_cfg ? cfg : hit_ctrl ? ctrl : hit_iaddr ? ind_addr
		: hit_idata ? ind_data : hit_scr ? scratch[sel_word[2:0]] : 24'h000000;
	wire host_wr_ok = host_take && host_cmd.wr && !host_err;
	wire ram_we = host_wr_ok && !local_hit;
	wire [23:0] ram_rdata;
	wire [23:0] ctrl_wval = host_cmd.wdata & `ECRB_CONTROL_WMASK;

	always_comb begin
		next_state = state;
		case (state)
			ecrb_pkg::ECRB_IDLE: begin
				if (ind_go) begin
					next_state = ecrb_pkg::ECRB_IND_FETCH;
				end else if (host_take) begin
					next_state = ecrb_pkg::ECRB_HOST;
				end
			end
			ecrb_pkg::ECRB_IND_FETCH: next_state = ecrb_pkg::ECRB_IND_LOAD;
			ecrb_pkg::ECRB_HOST: next_state = ecrb_pkg::ECRB_IDLE;
			ecrb_pkg::ECRB_IND_LOAD: next_state = ecrb_pkg::ECRB_IDLE;
			default: next_state = ecrb_pkg::ECRB_IDLE;
		endcase
	end

	ecrb_ram u_ram (
		.mclk(mclk),
		.rst_n(rst_n),
		.we(ram_we),
		.addr(sel_word),
		.wdata(host_cmd.wdata),
		.rdata(ram_rdata)
	);

	// ****************************************
	// sequencing
	// ****************************************
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ecrb_pkg::ECRB_IDLE;
			tick_pending <= 1'b0;
			hit_q <= 1'b0;
			local_q <= 24'h000000;
			wr_q <= 1'b0;
			err_q <= 1'b0;
		end else begin
			state <= next_state;
			// a tick in the same cycle as the check keeps it pending
			tick_pending <= sample_tick || (tick_pending && (state != ecrb_pkg::ECRB_IDLE));
			if (state == ecrb_pkg::ECRB_IDLE) begin
				hit_q <= local_hit;
				local_q <= local_val;
				wr_q <= host_cmd.wr;
				err_q <= host_err;
			end
		end
	end

	// ****************************************
	// host answer
	// ****************************************
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			host_ack <= 1'b0;
			host_addr_err <= 1'b0;
			host_rdata <= 24'h000000;
		end else begin
			host_ack <= state == ecrb_pkg::ECRB_HOST;
			if (state == ecrb_pkg::ECRB_HOST) begin
				host_addr_err <= err_q;
				host_rdata <= (err_q || wr_q) ? 24'h000000 : (hit_q ? local_q : ram_rdata);
			end
		end
	end

	// ****************************************
	// configuration, control, indirect read
	// ****************************************
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cfg <= `ECRB_CONFIG_RST;
			ctrl <= `ECRB_CONTROL_RST;
			ind_addr <= 24'h000000;
			ind_data <= 24'h000000;
		end else begin
			if (flash_restore) begin
				cfg <= nv_cfg;
				ctrl <= nv_ctrl;
			end else if (host_wr_ok && hit_cfg) begin
				cfg <= host_cmd.wdata;
			end else if (host_wr_ok && hit_ctrl) begin
				ctrl <= ctrl_wval;
			end
			if (state == ecrb_pkg::ECRB_IND_LOAD) begin
				ind_data <= hit_q ? local_q : ram_rdata;
				ind_addr <= ind_addr & `ECRB_IND_ADDR_MASK;
			end else if (host_wr_ok && hit_iaddr) begin
				ind_addr <= host_cmd.wdata;
			end
			// host writes to the read-data word are dropped: it is an output register
		end
	end

	// ****************************************
	// scratch and flash image
	// ****************************************
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < `ECRB_SCRATCH_COUNT; i++) begin
				scratch[i] <= (i == 0) ? `ECRB_SCRATCH0_RST
					: (i == 1) ? `ECRB_SCRATCH1_RST : `ECRB_SCRATCH_RST;
				nv_scratch[i] <= (i == 0) ? `ECRB_SCRATCH0_RST
					: (i == 1) ? `ECRB_SCRATCH1_RST : `ECRB_SCRATCH_RST;
			end
			nv_cfg <= `ECRB_CONFIG_RST;
			nv_ctrl <= `ECRB_CONTROL_RST;
		end else begin
			for (int i = 0; i < `ECRB_SCRATCH_COUNT; i++) begin
				if (flash_restore) begin
					scratch[i] <= nv_scratch[i];
				end else if (host_wr_ok && hit_scr && sel_word[2:0] == i[2:0]) begin
					scratch[i] <= host_cmd.wdata;
				end
				if (flash_save) begin
					nv_scratch[i] <= scratch[i];
				end
			end
			if (flash_save) begin
				nv_cfg <= cfg;
				nv_ctrl <= ctrl;
			end
		end
	end

	// ****************************************
	// uart mode pin synchroniser
	// ****************************************
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			uart_s1 <= 1'b0;
			uart_s2 <= 1'b0;
			uart_s3 <= 1'b0;
			uart_mode <= 1'b0;
		end else begin
			uart_s1 <= uart_mode_pin;
			uart_s2 <= uart_s1;
			uart_s3 <= uart_s2;
			if (uart_s2 == uart_s3) begin
				uart_mode <= uart_s3;
			end
		end
	end

	// ****************************************
	// sample path
	// ****************************************
	wire [2:0] v_present = present_mask(cfg.missing_voltage_sensor);
	wire [23:0] v1_in = v_present[0] ? voltage_input_1 : 24'h000000;
	wire [23:0] v2_in = v_present[1] ? voltage_input_2 : 24'h000000;
	wire [23:0] v3_in = v_present[2] ? voltage_input_3 : 24'h000000;
	wire [23:0] v1_pol = cfg.invert_voltage_in1 ? sat_neg(v1_in) : v1_in;
	wire [23:0] v2_pol = cfg.invert_voltage_in2 ? sat_neg(v2_in) : v2_in;
	wire [23:0] v3_pol = cfg.invert_voltage_in3 ? sat_neg(v3_in) : v3_in;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			v1_q <= 24'h000000;
			v2_q <= 24'h000000;
			v3_q <= 24'h000000;
			phase_voltage_a <= 24'h000000;
			phase_voltage_b <= 24'h000000;
			phase_voltage_c <= 24'h000000;
		end else begin
			v1_q <= v1_pol;
			v2_q <= v2_pol;
			v3_q <= v3_pol;
			phase_voltage_a <= cfg.delta_voltage_mode ? sat_sub(v1_pol, v2_pol) : v1_pol;
			phase_voltage_b <= cfg.delta_voltage_mode ? sat_sub(v2_pol, v3_pol) : v2_pol;
			phase_voltage_c <= cfg.delta_voltage_mode ? sat_sub(v3_pol, v1_pol) : v3_pol;
		end
	end

	// ****************************************
	// mode outputs and pins
	// ****************************************
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			init_done <= 1'b0;
			single_target_mode <= 1'b0;
			power_phase_include <= 3'b111;
			voltage_present <= 3'b111;
			current_present <= 3'b111;
			delta_voltage_mode <= 1'b0;
			neutral_leg_current <= 1'b0;
			line_lock <= 1'b0;
			temp_gain_comp_en <= 1'b0;
			multipurpose_pin_5 <= 1'b0;
			multipurpose_pin_5_oe_n <= 1'b1;
			multipurpose_pin_6 <= 1'b0;
			multipurpose_pin_6_oe_n <= 1'b1;
			multipurpose_pin_7 <= 1'b0;
			multipurpose_pin_7_oe_n <= 1'b1;
			multipurpose_pin_8 <= 1'b0;
			multipurpose_pin_8_oe_n <= 1'b1;
		end else begin
			init_done <= 1'b1;
			if (!init_done) begin
				single_target_mode <= ctrl.single_target;
			end else if (flash_restore) begin
				// a flash reload counts as a fresh initialisation
				single_target_mode <= nv_ctrl.single_target;
			end
			power_phase_include <= present_mask(cfg.power_phase_exclude);
			voltage_present <= v_present;
			current_present <= present_mask(cfg.missing_current_sensor);
			delta_voltage_mode <= cfg.delta_voltage_mode;
			neutral_leg_current <= cfg.neutral_leg_current;
			line_lock <= ctrl.line_lock;
			temp_gain_comp_en <= ctrl.temp_gain_comp_en;
			multipurpose_pin_5 <= device_selected;
			multipurpose_pin_5_oe_n <= !(ctrl.io5_select_en && uart_mode);
			multipurpose_pin_6 <= v1_q[23];
			multipurpose_pin_6_oe_n <= !cfg.phase_a_sign_out_en;
			multipurpose_pin_7 <= v2_q[23];
			multipurpose_pin_7_oe_n <= !cfg.phase_b_sign_out_en;
			multipurpose_pin_8 <= v3_q[23];
			multipurpose_pin_8_oe_n <= !cfg.phase_c_sign_out_en;
		end
	end
endmodule

/* tb/ecrb_top_props.sv */
`timescale 1ns/1ns
module ecrb_top_props (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic host_req,
	input wire ecrb_pkg::ecrb_host_req_s host_cmd,
	input wire logic host_ack,
	input wire logic [23:0] host_rdata,
	input wire logic flash_restore,
	input wire logic device_selected,
	input wire logic [2:0] power_phase_include,
	input wire logic [2:0] voltage_present,
	input wire logic [2:0] current_present,
	input wire logic line_lock,
	input wire logic temp_gain_comp_en,
	input wire logic single_target_mode,
	input wire logic multipurpose_pin_5,
	input wire logic multipurpose_pin_5_oe_n
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	ack_bound_a: assert property ($rose(host_req) |-> ##[2:8] host_ack)
		else $error("ack missing");
	ack_pulse_a: assert property (host_ack |=> !host_ack)
		else $error("ack too long");
	ctrl_rsv_a: assert property (host_ack && !host_cmd.wr && !host_cmd.byte_mode
		&& host_cmd.addr == 10'h003 |-> (host_rdata & 24'hFFFF8B) == 24'h000000)
		else $error("control reserved bits set");
	excl_code_a: assert property ($onehot0(~power_phase_include))
		else $error("two phases excluded");
	vmiss_code_a: assert property ($onehot0(~voltage_present))
		else $error("two voltage inputs missing");
	imiss_code_a: assert property ($onehot0(~current_present))
		else $error("two current inputs missing");
	pin5_follow_a: assert property (!multipurpose_pin_5_oe_n && $stable(device_selected)
		|-> multipurpose_pin_5 == device_selected)
		else $error("select pin wrong");
	single_init_a: assert property ($changed(single_target_mode) |-> $past(flash_restore))
		else $error("single target changed outside init");
	lock_cause_a: assert property ($changed(line_lock) |-> $past(host_req)
		|| $past(host_req, 2) || $past(flash_restore) || $past(flash_restore, 2))
		else $error("line lock changed alone");
	temp_cause_a: assert property ($changed(temp_gain_comp_en) |-> $past(host_req)
		|| $past(host_req, 2) || $past(flash_restore) || $past(flash_restore, 2))
		else $error("temp comp changed alone");
endmodule

bind ecrb_top ecrb_top_props i_props (.mclk, .rst_n, .host_req, .host_cmd, .host_ack,
	.host_rdata, .flash_restore, .device_selected, .power_phase_include, .voltage_present,
	.current_present, .line_lock, .temp_gain_comp_en, .single_target_mode,
	.multipurpose_pin_5, .multipurpose_pin_5_oe_n);

/* tb/ecrb_host_model.sv */
`timescale 1ns/1ns
module ecrb_host_model (
	input wire logic mclk,
	input wire logic host_ack,
	input wire logic host_addr_err,
	input wire logic [23:0] host_rdata,
	output logic host_req,
	output ecrb_pkg::ecrb_host_req_s host_cmd
);
	initial begin
		host_req = 1'b0;
		host_cmd = '0;
	end
	// one word per access; request held up to the edge that samples the ack
	task automatic access(input ecrb_pkg::ecrb_host_req_s cmd, output logic [23:0] rd,
		output logic err);
		int n;
		n = 0;
		@(posedge mclk);
		host_req <= 1'b1;
		host_cmd <= cmd;
		do begin
			@(posedge mclk);
			n++;
		end while (host_ack !== 1'b1 && n < 20);
		if (host_ack === 1'b1) begin
			rd = host_rdata;
			err = host_addr_err;
		end else begin
			// no answer: unknown values make every compare fail
			rd = 'x;
			err = 1'bx;
		end
		host_req <= 1'b0;
	endtask
endmodule

/* tb/tb_ecrb_top.sv */
`timescale 1ns/1ns
module tb_ecrb_top;
	logic mclk, rst_n, host_req, host_ack, host_addr_err, sample_tick, flash_save;
	logic flash_restore, uart_mode_pin, device_selected, delta_voltage_mode;
	logic neutral_leg_current, line_lock, temp_gain_comp_en, single_target_mode;
	logic multipurpose_pin_5, multipurpose_pin_6, multipurpose_pin_7, multipurpose_pin_8;
	logic multipurpose_pin_5_oe_n, multipurpose_pin_6_oe_n;
	logic multipurpose_pin_7_oe_n, multipurpose_pin_8_oe_n;
	logic [23:0] host_rdata, voltage_input_1, voltage_input_2, voltage_input_3, cfg;
	logic [23:0] phase_voltage_a, phase_voltage_b, phase_voltage_c;
	logic [2:0] power_phase_include, voltage_present, current_present, e;
	ecrb_pkg::ecrb_host_req_s host_cmd;
	int fail_count, num_checks, cycles;
	// ****************************************
	// rows: command, expected data, expected error
	// ****************************************
	localparam logic [60:0] rows [9] = '{
		{2'b00, 10'h002, 24'h000000, 24'h000000, 1'b0},
		{2'b00, 10'h0F8, 24'h000000, 24'h00003E, 1'b0},
		{2'b01, 10'h2EB, 24'h000000, 24'h00029B, 1'b0},
		{2'b10, 10'h003, 24'hFFFFFF, 24'h000000, 1'b0},
		{2'b00, 10'h003, 24'h000000, 24'h000074, 1'b0},
		{2'b11, 10'h2FD, 24'hABCDEF, 24'h000000, 1'b0},
		{2'b00, 10'h0FF, 24'h000000, 24'hABCDEF, 1'b0},
		{2'b01, 10'h005, 24'h000000, 24'h000000, 1'b1},
		{2'b01, 10'h300, 24'h000000, 24'h000000, 1'b1}};
	ecrb_top i_dut (.mclk, .rst_n, .host_req, .host_cmd, .host_ack, .host_addr_err,
		.host_rdata, .sample_tick, .flash_save, .flash_restore, .uart_mode_pin,
		.device_selected, .voltage_input_1, .voltage_input_2, .voltage_input_3,
		.phase_voltage_a, .phase_voltage_b, .phase_voltage_c, .power_phase_include,
		.voltage_present, .current_present, .delta_voltage_mode, .neutral_leg_current,
		.line_lock, .temp_gain_comp_en, .single_target_mode, .multipurpose_pin_5,
		.multipurpose_pin_5_oe_n, .multipurpose_pin_6, .multipurpose_pin_6_oe_n,
		.multipurpose_pin_7, .multipurpose_pin_7_oe_n, .multipurpose_pin_8,
		.multipurpose_pin_8_oe_n);
	ecrb_host_model i_host (.mclk, .host_ack, .host_addr_err, .host_rdata, .host_req,
		.host_cmd);
	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic acc(input logic [35:0] c, input logic [23:0] exp, input logic er);
		logic [23:0] rd;
		logic err;
		i_host.access(c, rd, err);
		chk(rd, exp);
		chk({23'h0, err}, {23'h0, er});
	endtask
	task automatic close_out();
		$display("checks=%0d mismatches=%0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 2000) begin
			fail_count++;
			close_out();
		end
	end
	initial begin
		rst_n = 1'b0;
		{sample_tick, flash_save, flash_restore, uart_mode_pin, device_selected} = 5'h03;
		voltage_input_1 = 24'h000010;
		voltage_input_2 = 24'h800000;
		voltage_input_3 = 24'hFFFFF0;
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		for (int i = 0; i < 9; i++) begin
			acc(rows[i][60:25], rows[i][24:1], rows[i][0]);
		end
		chk({20'h0, line_lock, temp_gain_comp_en, multipurpose_pin_5_oe_n,
			multipurpose_pin_5}, 24'h00000D);
		device_selected <= 1'b0;
		repeat (3) @(posedge mclk);
		chk({23'h0, multipurpose_pin_5}, 24'h000000);
		uart_mode_pin <= 1'b0;
		repeat (6) @(posedge mclk);
		chk({23'h0, multipurpose_pin_5_oe_n}, 24'h000001);
		$display("table done");
		for (int k = 0; k < 4; k++) begin
			cfg = {16'h0000, 2'(k), k == 3, 2'(k), 1'b1, 2'(k)};
			acc({2'b10, 10'h002, cfg}, 24'h0, 1'b0);
			repeat (2) @(posedge mclk);
			e = (k == 0) ? 3'h7 : 3'h7 ^ (3'h1 << (k - 1));
			chk({21'h0, power_phase_include}, {21'h0, e});
			chk({21'h0, voltage_present}, {21'h0, e});
			chk({21'h0, current_present}, {21'h0, e});
			chk({22'h0, delta_voltage_mode, neutral_leg_current}, {22'h0, k == 3, 1'b1});
			if (k == 3) begin
				chk(phase_voltage_a, 24'h7FFFFF);
				chk(phase_voltage_c, 24'hFFFFF0);
			end
		end
		acc({2'b10, 10'h002, 24'h7E0000}, 24'h0, 1'b0);
		repeat (3) @(posedge mclk);
		chk(phase_voltage_a, 24'hFFFFF0);
		chk(phase_voltage_b, 24'h7FFFFF);
		chk(phase_voltage_c, 24'h000010);
		chk({18'h0, multipurpose_pin_8, multipurpose_pin_7, multipurpose_pin_6,
			multipurpose_pin_8_oe_n, multipurpose_pin_7_oe_n,
			multipurpose_pin_6_oe_n}, 24'h000008);
		acc({2'b10, 10'h002, 24'h000000}, 24'h0, 1'b0);
		repeat (2) @(posedge mclk);
		chk({21'h0, multipurpose_pin_8_oe_n, multipurpose_pin_7_oe_n,
			multipurpose_pin_6_oe_n}, 24'h000007);
		$display("modes done");
		acc({2'b10, 10'h040, 24'h5A5A5A}, 24'h0, 1'b0);
		acc({2'b10, 10'h00B, 24'h010040}, 24'h0, 1'b0);
		acc({2'b00, 10'h00B, 24'h0}, 24'h010040, 1'b0);
		@(posedge mclk) sample_tick <= 1'b1;
		@(posedge mclk) sample_tick <= 1'b0;
		repeat (5) @(posedge mclk);
		acc({2'b00, 10'h00B, 24'h0}, 24'h000040, 1'b0);
		acc({2'b00, 10'h00C, 24'h0}, 24'h5A5A5A, 1'b0);
		acc({2'b10, 10'h00C, 24'h123456}, 24'h0, 1'b0);
		acc({2'b00, 10'h00C, 24'h0}, 24'h5A5A5A, 1'b0);
		$display("indirect done");
		acc({2'b10, 10'h0F8, 24'h111111}, 24'h0, 1'b0);
		@(posedge mclk) flash_save <= 1'b1;
		@(posedge mclk) flash_save <= 1'b0;
		acc({2'b10, 10'h0F8, 24'h222222}, 24'h0, 1'b0);
		@(posedge mclk) flash_restore <= 1'b1;
		@(posedge mclk) flash_restore <= 1'b0;
		repeat (2) @(posedge mclk);
		chk({23'h0, single_target_mode}, 24'h000001);
		acc({2'b00, 10'h0F8, 24'h0}, 24'h111111, 1'b0);
		@(posedge mclk) rst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		chk({16'h0, single_target_mode, power_phase_include, multipurpose_pin_5_oe_n,
			multipurpose_pin_6_oe_n, multipurpose_pin_7_oe_n,
			multipurpose_pin_8_oe_n}, 24'h00007F);
		@(posedge mclk) rst_n <= 1'b1;
		acc({2'b00, 10'h0F8, 24'h0}, 24'h00003E, 1'b0);
		$display("flash done");
		close_out();
	end
endmodule
